// *** rtl/cfg_route_pkg.sv ***
package cfg_route_pkg;
   // Host I/O port addresses of the selector and the data window.
   localparam logic [15:0] SEL_IO_ADDR = 16'h0cf8;
   localparam logic [15:0] WIN_IO_ADDR = 16'h0cfc;
   // Selector field positions.
   localparam int EN_BIT = 31;
   localparam int BUS_LSB = 16;
   localparam int DEV_LSB = 11;
   localparam int FN_LSB = 8;
   localparam int REG_LSB = 2;
   // Writable selector bits; 30:24 and 1:0 read as zero.
   localparam logic [31:0] SEL_WMASK = 32'h80ff_fffc;
   localparam logic [31:0] SEL_RESET = 32'h0000_0000;
   // Hardwired identities of the internal functions.
   localparam logic [4:0] LINK_FN_DEV = 5'h00;
   localparam logic [4:0] GFX_FN_DEV = 5'h01;
   localparam logic [7:0] ROOT_BUS = 8'h00;
   // Bridge window register layout inside the graphics function.
   localparam logic [5:0] BUSNUM_DW = 6'h06;
   localparam logic [7:0] UP_BUS_RESET = 8'h00;
   localparam logic [7:0] SEC_BUS_RESET = 8'h00;
   localparam logic [7:0] HIGH_BUS_RESET = 8'h00;
   localparam int STRAP_W = 8;
   // Destination of a forwarded cycle.
   typedef enum logic [1:0] {
      DST_LINK_IO = 2'b00,
      DST_LINK_CFG = 2'b01,
      DST_GFX_CFG = 2'b10
   } dest_e;
endpackage

// *** rtl/cfg_route_if.sv ***
`timescale 1ns/10ps
// Join between the router and the downstream agents.
interface cfg_route_if;
   import cfg_route_pkg::*;
   logic req;
   dest_e dest;
   logic cfg_type1;
   logic write;
   logic [31:0] addr;
   logic [3:0] be;
   logic [31:0] wdata;
   logic done;
   logic [31:0] rdata;
   modport router (output req, dest, cfg_type1, write, addr, be, wdata,
                   input done, rdata);
   modport agent (input req, dest, cfg_type1, write, addr, be, wdata,
                  output done, rdata);
endinterface

// *** rtl/bus_window_match.sv ***
`timescale 1ns/10ps
// Classifies a nonzero bus number against the graphics bridge window.
module bus_window_match
   import cfg_route_pkg::*;
(
   input wire logic [7:0] bus_num,
   input wire logic [7:0] sec_bus,
   input wire logic [7:0] high_bus,
   output logic to_gfx,
   output logic gfx_type1
);
   always_comb begin
      to_gfx = 1'b0;
      gfx_type1 = 1'b0;
      if (bus_num != ROOT_BUS) begin
         if (bus_num == sec_bus) begin
            to_gfx = 1'b1;
         end else if (bus_num > sec_bus && bus_num <= high_bus) begin
            to_gfx = 1'b1;
            gfx_type1 = 1'b1;
         end
      end
   end
endmodule // bus_window_match

// *** rtl/cfg_agent_end.sv ***
`timescale 1ns/10ps
// Downstream end: answers every forwarded cycle one clock later.
module cfg_agent_end
   import cfg_route_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   cfg_route_if.agent lnk,
   output logic seen_r,
   output dest_e seen_dest_r,
   output logic seen_type1_r,
   output logic seen_write_r,
   output logic [31:0] seen_addr_r,
   output logic [3:0] seen_be_r,
   output logic [31:0] seen_wdata_r,
   input wire logic [31:0] resp_data
);
   logic done_r;
   logic [31:0] rdata_r;
   assign lnk.done = done_r;
   assign lnk.rdata = rdata_r;

   // Capture the cycle for the user side and complete it on the link.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         seen_r <= 1'b0;
         seen_dest_r <= DST_LINK_IO;
         seen_type1_r <= 1'b0;
         seen_write_r <= 1'b0;
         seen_addr_r <= 32'h0000_0000;
         seen_be_r <= 4'h0;
         seen_wdata_r <= 32'h0000_0000;
      end else begin
         done_r <= lnk.req && !done_r;
         seen_r <= lnk.req && !done_r;
         if (lnk.req && !done_r) begin
            rdata_r <= resp_data;
            seen_dest_r <= lnk.dest;
            seen_type1_r <= lnk.cfg_type1;
            seen_write_r <= lnk.write;
            seen_addr_r <= lnk.addr;
            seen_be_r <= lnk.be;
            seen_wdata_r <= lnk.wdata;
         end
      end
   end
endmodule // cfg_agent_end

// *** rtl/cfg_router_end.sv ***
`timescale 1ns/10ps
// Function
// - Decode bus and device fields each access.
// - Bus zero means root configuration bus.
// - Link bridge function is fixed device 0.
// - Graphics bridge function is fixed device 1.
// - Enabled internal hits never reach the link.
// - Disabled internal function forwards as Type 0.
// - Bus outside graphics window: link Type 1.
// - Bus equals secondary: graphics port Type 0.
// - Bus inside window above secondary: graphics Type 1.
// - Upstream bus number reads zero, ignores writes.
// - Byte, word, dword accesses; selector dword only.
// - Multi-byte fields are little-endian.
// - Software masks and preserves reserved bits.
// - Software writes selector without merging.
// - Reserved locations may read any value.
// - Software never writes vendor-reserved locations.
// - Full reset loads default register values.
// - Some defaults come from straps at reset.
// - Only address-plus-data-window mechanism supported.
// - Registers reached in host I/O space.
// - Selector at 0CF8h, data window at 0CFCh.
// - Bit 31 clear means no configuration cycle.
// - Narrow selector access passes as I/O.
module cfg_router_end
   import cfg_route_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic io_req,
   input wire logic io_write,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic [31:0] io_wdata,
   output logic io_done_r,
   output logic [31:0] io_rdata_r,
   input wire logic link_fn_en,
   input wire logic gfx_fn_en,
   input wire logic [STRAP_W-1:0] strap_sec_bus,
   cfg_route_if.router lnk
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FWD = 2'b01,
      ST_DONE = 2'b10
   } state_e;

   state_e state_r;
   logic [31:0] sel_r;
   logic [7:0] sec_bus_r;
   logic [7:0] high_bus_r;
   logic strap_taken_r;
   logic req_r;
   dest_e dest_r;
   logic type1_r;
   logic write_r;
   logic [31:0] addr_r;
   logic [3:0] be_r;
   logic [31:0] wdata_r;
   logic [31:0] rdata_nxt;
   logic [31:0] fn_rdata;
   logic [31:0] merged_wdata;
   logic to_gfx;
   logic gfx_type1;
   logic sel_hit;
   logic sel_narrow;
   logic win_hit;
   logic cfg_on;
   logic [7:0] bus_f;
   logic [4:0] dev_f;
   logic [2:0] fn_f;
   logic [5:0] reg_f;
   logic root_bus;
   logic hit_link_fn;
   logic hit_gfx_fn;
   logic internal_hit;

   assign lnk.req = req_r;
   assign lnk.dest = dest_r;
   assign lnk.cfg_type1 = type1_r;
   assign lnk.write = write_r;
   assign lnk.addr = addr_r;
   assign lnk.be = be_r;
   assign lnk.wdata = wdata_r;

   // Selector fields that choose the target of every window access.
   assign bus_f = sel_r[BUS_LSB +: 8];
   assign dev_f = sel_r[DEV_LSB +: 5];
   assign fn_f = sel_r[FN_LSB +: 3];
   assign reg_f = sel_r[REG_LSB +: 6];
   assign cfg_on = sel_r[EN_BIT];
   assign root_bus = (bus_f == ROOT_BUS);
   assign hit_link_fn = root_bus && dev_f == LINK_FN_DEV && fn_f == 3'h0;
   assign hit_gfx_fn = root_bus && dev_f == GFX_FN_DEV && fn_f == 3'h0;
   assign internal_hit = (hit_link_fn && link_fn_en) ||
                         (hit_gfx_fn && gfx_fn_en);

   // Port decode on the dword address, so a byte or word access anywhere
   // in the window dword reaches it; the selector claims only full dwords.
   assign sel_hit = io_addr[15:2] == SEL_IO_ADDR[15:2] &&
                    io_be == 4'hf;
   assign sel_narrow = io_addr[15:2] == SEL_IO_ADDR[15:2] &&
                       io_be != 4'hf;
   assign win_hit = io_addr[15:2] == WIN_IO_ADDR[15:2];

   bus_window_match u_match (
      .bus_num(bus_f),
      .sec_bus(sec_bus_r),
      .high_bus(high_bus_r),
      .to_gfx(to_gfx),
      .gfx_type1(gfx_type1)
   );

   // Graphics bridge bus-number dword: byte 0 upstream, 1 secondary,
   // 2 highest downstream, little-endian by byte lane.
   always_comb begin
      fn_rdata = 32'h0000_0000;
      if (hit_gfx_fn && reg_f == BUSNUM_DW) begin
         fn_rdata = {8'h00, high_bus_r, sec_bus_r, UP_BUS_RESET};
      end
   end

   // Byte-lane merge of a write into the bus-number dword.
   always_comb begin
      merged_wdata = {8'h00, high_bus_r, sec_bus_r, UP_BUS_RESET};
      if (io_be[1]) begin
         merged_wdata[15:8] = io_wdata[15:8];
      end
      if (io_be[2]) begin
         merged_wdata[23:16] = io_wdata[23:16];
      end
   end

   // Read value of an I/O access completed here; other locations of the
   // internal functions read zero, which is a legal arbitrary value.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (sel_hit) begin
         rdata_nxt = sel_r;
      end else if (win_hit && cfg_on && internal_hit) begin
         rdata_nxt = fn_rdata;
      end
   end

   // Selector register; reserved bits are forced to zero on write.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= SEL_RESET;
      end else if (state_r == ST_IDLE && io_req && io_write && sel_hit) begin
         sel_r <= io_wdata & SEL_WMASK;
      end
   end

   // Bridge window registers; the secondary default is a strap caught at
   // the first clock after reset release, never inside the async reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sec_bus_r <= SEC_BUS_RESET;
         high_bus_r <= HIGH_BUS_RESET;
         strap_taken_r <= 1'b0;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         sec_bus_r <= strap_sec_bus;
      end else if (state_r == ST_IDLE && io_req && io_write && win_hit &&
                   cfg_on && gfx_fn_en && hit_gfx_fn &&
                   reg_f == BUSNUM_DW) begin
         // Byte 0 (upstream) is not stored, so it stays zero.
         sec_bus_r <= merged_wdata[15:8];
         high_bus_r <= merged_wdata[23:16];
      end
   end

   // Access sequencer: local answers take one cycle, forwarded ones wait
   // for the agent. The host must hold io_req low after io_done_r.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         io_done_r <= 1'b0;
         io_rdata_r <= 32'h0000_0000;
         req_r <= 1'b0;
         dest_r <= DST_LINK_IO;
         type1_r <= 1'b0;
         write_r <= 1'b0;
         addr_r <= 32'h0000_0000;
         be_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
      end else begin
         io_done_r <= 1'b0;
         unique case (state_r)
            ST_IDLE: begin
               if (io_req) begin
                  write_r <= io_write;
                  be_r <= io_be;
                  wdata_r <= io_wdata;
                  if (sel_narrow || (win_hit && !cfg_on) ||
                      (!sel_hit && !win_hit)) begin
                     req_r <= 1'b1;
                     dest_r <= DST_LINK_IO;
                     type1_r <= 1'b0;
                     addr_r <= {16'h0000, io_addr};
                     state_r <= ST_FWD;
                  end else if (sel_hit || internal_hit) begin
                     io_rdata_r <= rdata_nxt;
                     io_done_r <= 1'b1;
                     state_r <= ST_DONE;
                  end else begin
                     req_r <= 1'b1;
                     addr_r <= sel_r;
                     if (root_bus) begin
                        dest_r <= DST_LINK_CFG;
                        type1_r <= 1'b0;
                     end else if (to_gfx) begin
                        dest_r <= DST_GFX_CFG;
                        type1_r <= gfx_type1;
                     end else begin
                        dest_r <= DST_LINK_CFG;
                        type1_r <= 1'b1;
                     end
                     state_r <= ST_FWD;
                  end
               end
            end
            ST_FWD: begin
               if (lnk.done) begin
                  req_r <= 1'b0;
                  io_rdata_r <= lnk.rdata;
                  io_done_r <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // cfg_router_end

// *** tb/cfg_route_checker.sv ***
`timescale 1ns/10ps
// Watches the forwarded-cycle handshake between router and agent.
module cfg_route_checker
   import cfg_route_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req,
   input dest_e dest,
   input wire logic cfg_type1,
   input wire logic [31:0] addr,
   input wire logic done
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Handshake shape: one answer per request, then release.
   a_req_held_stable: assert property (req && !done |=> req && $stable(addr)
      && $stable(dest) && $stable(cfg_type1)) else $error("req not held");
   a_done_one_later: assert property ($rose(req) |=> done)
      else $error("done late");
   a_done_single_pulse: assert property (done |=> !done)
      else $error("done too long");
   a_req_drop_after: assert property (done |=> !req)
      else $error("req not dropped");
   a_done_needs_req: assert property (done |-> req)
      else $error("done without req");
   // Routing relations between the selector fields and the destination.
   a_root_type0_link: assert property (req && dest == DST_LINK_CFG &&
      !cfg_type1 |-> addr[23:16] == 8'h00) else $error("type0 off root");
   a_type1_not_root: assert property (req && cfg_type1 |->
      addr[23:16] != 8'h00) else $error("type1 on root");
   a_gfx_not_root: assert property (req && dest == DST_GFX_CFG |->
      addr[23:16] != 8'h00) else $error("gfx cycle on root");
   a_cfg_needs_enable: assert property (req && dest != DST_LINK_IO |->
      addr[31]) else $error("cycle with enable clear");
   c_gfx_type1: cover property (req && dest == DST_GFX_CFG && cfg_type1);
   c_link_type0: cover property (req && dest == DST_LINK_CFG && !cfg_type1);
   c_link_io: cover property (req && dest == DST_LINK_IO);
endmodule // cfg_route_checker

// *** tb/config_cycle_router_tb_top.sv ***
`timescale 1ns/10ps
module config_cycle_router_tb_top;
   import cfg_route_pkg::*;
   logic clk_sys, rst_n, io_req, io_write, io_done_r, hit;
   logic link_fn_en, gfx_fn_en, seen_r, seen_type1_r, seen_write_r;
   logic [15:0] io_addr;
   logic [3:0] io_be, seen_be_r;
   logic [31:0] io_wdata, io_rdata_r, rd, seen_addr_r, seen_wdata_r;
   dest_e seen_dest_r;
   int fail_count, samples_checked;
   cfg_route_if i_lnk();
   cfg_router_end i_cfg_router_end(.clk_sys(clk_sys), .rst_n(rst_n),
      .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
      .io_be(io_be), .io_wdata(io_wdata), .io_done_r(io_done_r),
      .io_rdata_r(io_rdata_r), .link_fn_en(link_fn_en),
      .gfx_fn_en(gfx_fn_en), .strap_sec_bus(8'h05), .lnk(i_lnk.router));
   cfg_agent_end i_cfg_agent_end(.clk_sys(clk_sys), .rst_n(rst_n),
      .lnk(i_lnk.agent), .seen_r(seen_r), .seen_dest_r(seen_dest_r),
      .seen_type1_r(seen_type1_r), .seen_write_r(seen_write_r),
      .seen_addr_r(seen_addr_r), .seen_be_r(seen_be_r),
      .seen_wdata_r(seen_wdata_r), .resp_data(32'h1234_5678));
   cfg_route_checker i_chk(.clk_sys(clk_sys), .rst_n(rst_n),
      .req(i_lnk.req), .dest(i_lnk.dest), .cfg_type1(i_lnk.cfg_type1),
      .addr(i_lnk.addr), .done(i_lnk.done));
   // Free-running 40 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One host access; notes whether the agent saw a forwarded cycle.
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [3:0] b, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      io_req <= 1'b1;
      io_write <= w;
      io_addr <= a;
      io_be <= b;
      io_wdata <= d;
      hit = 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (seen_r === 1'b1) hit = 1'b1;
      end while (io_done_r !== 1'b1 && n < 10);
      rd = io_rdata_r;
      io_req <= 1'b0;
      // A missing completion is a mismatch and ends the run at once.
      if (io_done_r !== 1'b1) begin
         chk({31'h0, io_done_r}, 32'h1);
         test_done();
      end
      // The cycle after completion is refused, so rest an extra edge; the
      // done pulse must have ended by then.
      @(posedge clk_sys);
      chk({31'h0, io_done_r}, 32'h0);
   endtask
   function automatic logic [31:0] cfg(input logic [7:0] bus,
                                       input logic [4:0] dev);
      return {1'b1, 7'h0, bus, dev, 3'h0, BUSNUM_DW, 2'h0};
   endfunction
   // Loads the selector, reads the window and checks where it went.
   task automatic route(input logic [31:0] sel, input logic f,
                        input dest_e dd, input logic t);
      xfer(1'b1, SEL_IO_ADDR, 4'hf, sel);
      xfer(1'b0, WIN_IO_ADDR, 4'hf, 32'h0);
      chk({31'h0, hit}, {31'h0, f});
      if (f) begin
         chk({30'h0, seen_dest_r}, {30'h0, dd});
         chk({31'h0, seen_type1_r}, {31'h0, t});
         chk(seen_addr_r, dd == DST_LINK_IO ? {16'h0, WIN_IO_ADDR} : sel);
         chk(rd, 32'h1234_5678);
      end
   endtask
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      io_req = 1'b0;
      io_write = 1'b0;
      io_addr = 16'h0;
      io_be = 4'h0;
      io_wdata = 32'h0;
      link_fn_en = 1'b1;
      gfx_fn_en = 1'b1;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      xfer(1'b0, SEL_IO_ADDR, 4'hf, 32'h0);
      chk(rd, SEL_RESET);
      xfer(1'b1, SEL_IO_ADDR, 4'hf, 32'hffff_ffff);
      xfer(1'b1, SEL_IO_ADDR, 4'h3, 32'h0);
      chk({31'h0, hit}, 32'h1);
      chk({30'h0, seen_dest_r}, {30'h0, DST_LINK_IO});
      chk(seen_addr_r, {16'h0, SEL_IO_ADDR});
      xfer(1'b0, SEL_IO_ADDR, 4'hf, 32'h0);
      chk(rd, SEL_WMASK);
      xfer(1'b1, SEL_IO_ADDR, 4'hf, cfg(ROOT_BUS, GFX_FN_DEV));
      xfer(1'b0, WIN_IO_ADDR, 4'hf, 32'h0);
      chk(rd, 32'h0000_0500);
      xfer(1'b1, WIN_IO_ADDR, 4'h5, 32'h0008_00ff);
      xfer(1'b0, WIN_IO_ADDR, 4'hf, 32'h0);
      chk(rd, 32'h0008_0500);
      chk({31'h0, hit}, 32'h0);
      // Byte read of the secondary lane, masked as software would.
      xfer(1'b0, WIN_IO_ADDR | 16'h0001, 4'h2, 32'h0);
      chk(rd & 32'h0000_ff00, 32'h0000_0500);
      xfer(1'b1, WIN_IO_ADDR, 4'hf, {rd[31:16], 8'h05, rd[7:0]});
      route(cfg(8'h00, LINK_FN_DEV), 1'b0, DST_LINK_IO, 1'b0);
      route(cfg(8'h00, 5'h02), 1'b1, DST_LINK_CFG, 1'b0);
      route(cfg(8'h03, 5'h03), 1'b1, DST_LINK_CFG, 1'b1);
      route(cfg(8'h05, 5'h03), 1'b1, DST_GFX_CFG, 1'b0);
      route(cfg(8'h08, 5'h03), 1'b1, DST_GFX_CFG, 1'b1);
      route(cfg(8'h09, 5'h03), 1'b1, DST_LINK_CFG, 1'b1);
      route(cfg(8'h05, 5'h03) & 32'h7fff_ffff, 1'b1, DST_LINK_IO, 1'b0);
      // A forwarded write must carry its direction, lanes and data intact.
      xfer(1'b1, SEL_IO_ADDR, 4'hf, cfg(8'h05, 5'h03));
      xfer(1'b1, WIN_IO_ADDR, 4'h6, 32'h5a6b_7c8d);
      chk({31'h0, seen_write_r}, 32'h1);
      chk({28'h0, seen_be_r}, 32'h6);
      chk(seen_wdata_r, 32'h5a6b_7c8d);
      gfx_fn_en <= 1'b0;
      route(cfg(8'h00, GFX_FN_DEV), 1'b1, DST_LINK_CFG, 1'b0);
      link_fn_en <= 1'b0;
      route(cfg(8'h00, LINK_FN_DEV), 1'b1, DST_LINK_CFG, 1'b0);
      // A second reset must restore the selector and the window defaults,
      // so bus 8 falls outside the window again.
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      xfer(1'b0, SEL_IO_ADDR, 4'hf, 32'h0);
      chk(rd, SEL_RESET);
      route(cfg(8'h08, 5'h03), 1'b1, DST_LINK_CFG, 1'b1);
      test_done();
   end
endmodule // config_cycle_router_tb_top
